// ==== design/pin_function_mux.sv ====
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module pin_function_mux (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] variant_in,
  input wire logic watchdog_timeout_reset_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pins
  input wire logic test_clock_pin_in,
  output logic test_clock_pin_out,
  output logic test_clock_pin_oe_out,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  input wire logic port_c_bit0_pin_in,
  output logic port_c_bit0_pin_out,
  output logic port_c_bit0_pin_oe_out,
  input wire logic port_c_bit1_pin_in,
  output logic port_c_bit1_pin_out,
  output logic port_c_bit1_pin_oe_out,
  input wire logic port_c_bit2_pin_in,
  output logic port_c_bit2_pin_out,
  output logic port_c_bit2_pin_oe_out,
  input wire logic port_f_bit8_pin_in,
  output logic port_f_bit8_pin_out,
  output logic port_f_bit8_pin_oe_out,
  // peripheral side
  output logic debug_test_clock_out,
  output logic debug_test_clock_valid_out,
  output logic crystal_in_out,
  output logic ext_clock_in_zero_out,
  input wire logic crystal_out_in,
  input wire logic [3:0] clock_sources_in,
  input wire logic serial0_transmit_in,
  input wire logic serial0_single_wire_in,
  input wire logic serial0_transmit_oe_in,
  output logic serial0_receive_out,
  input wire logic crossbar_output_eleven_in,
  input wire logic crossbar_output_ten_in,
  output logic crossbar_input_two_out,
  input wire logic timer_b_channel_zero_in,
  input wire logic timer_b_channel_zero_oe_in,
  output logic timer_b_channel_zero_out,
  input wire logic timer_b_channel_one_in,
  input wire logic timer_b_channel_one_oe_in,
  output logic timer_b_channel_one_out,
  output logic [1:0] clock_out_source_sel_out,
  output pin_mux_pkg::pin_vec_t gpio_in_out,
  output logic core_rst_out
);
  import pin_mux_pkg::*;

  logic [7:0] periph_en_reg;
  logic [7:0] periph_en_next;
  logic [7:0] sel_c_reg;
  logic [7:0] sel_c_next;
  logic [1:0] sel_f_reg;
  logic [1:0] sel_f_next;
  pin_vec_t gpio_out_reg;
  pin_vec_t gpio_out_next;
  pin_vec_t gpio_dir_reg;
  pin_vec_t gpio_dir_next;
  logic [1:0] clock_out_select_reg;
  logic [1:0] clock_out_select_next;
  logic sw_reset_reg;
  logic sw_reset_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [7:0] wr_byte;
  logic wr_lane0;

  pin_vec_t pin_sync_w;
  logic reset_pin_low;
  logic reset_hold;
  logic c0_sel;
  c2_func_t c2_func;
  f8_func_t f8_func;
  logic c2_per;
  logic f8_per;
  logic f8_timer;
  logic c2_timer;

  pin_sync sync_d2 (.ref_clk_in(ref_clk_in), .d_in(test_clock_pin_in), .q_out(pin_sync_w[0]));
  pin_sync sync_d4 (.ref_clk_in(ref_clk_in), .d_in(reset_pin_in), .q_out(pin_sync_w[1]));
  pin_sync sync_c0 (.ref_clk_in(ref_clk_in), .d_in(port_c_bit0_pin_in), .q_out(pin_sync_w[2]));
  pin_sync sync_c1 (.ref_clk_in(ref_clk_in), .d_in(port_c_bit1_pin_in), .q_out(pin_sync_w[3]));
  pin_sync sync_c2 (.ref_clk_in(ref_clk_in), .d_in(port_c_bit2_pin_in), .q_out(pin_sync_w[4]));
  pin_sync sync_f8 (.ref_clk_in(ref_clk_in), .d_in(port_f_bit8_pin_in), .q_out(pin_sync_w[5]));

  // pin reset only counts while the pin still has its reset function
  assign reset_pin_low = periph_en_reg[`EN_RST_BIT] & ~pin_sync_w[`PIN_D4];
  assign reset_hold = reset_pin_low | watchdog_timeout_reset_in | sw_reset_reg;

  reset_release rel (
    .ref_clk_in(ref_clk_in),
    .por_in(sys_rst_in),
    .hold_in(reset_hold),
    .core_rst_out(core_rst_out)
  );

  assign wr_lane0 = avs_write_in & avs_byteenable_in[0];
  assign wr_byte = avs_writedata_in[7:0];

  // register bus: one wait cycle on every access, then acknowledge
  always_comb begin
    periph_en_next = periph_en_reg;
    sel_c_next = sel_c_reg;
    sel_f_next = sel_f_reg;
    gpio_out_next = gpio_out_reg;
    gpio_dir_next = gpio_dir_reg;
    clock_out_select_next = clock_out_select_reg;
    sw_reset_next = 1'b0;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    if ((avs_read_in | avs_write_in) & ~ack_reg) begin
      ack_next = 1'b1;
      rdata_next = 32'h0000_0000;
      if (avs_address_in == `ADDR_PERIPH_EN) begin
        rdata_next = {24'h00_0000, periph_en_reg};
        if (wr_lane0) periph_en_next = {2'b00, wr_byte[5:0]};
      end else if (avs_address_in == `ADDR_SEL_C) begin
        rdata_next = {24'h00_0000, sel_c_reg};
        if (wr_lane0) sel_c_next = wr_byte;
      end else if (avs_address_in == `ADDR_SEL_D) begin
        rdata_next = {30'h0000_0000, sel_f_reg};
        if (wr_lane0) sel_f_next = wr_byte[1:0];
      end else if (avs_address_in == `ADDR_GPIO_OUT) begin
        rdata_next = {26'h000_0000, gpio_out_reg};
        if (wr_lane0) gpio_out_next = wr_byte[5:0];
      end else if (avs_address_in == `ADDR_GPIO_DIR) begin
        rdata_next = {26'h000_0000, gpio_dir_reg};
        if (wr_lane0) gpio_dir_next = wr_byte[5:0];
      end else if (avs_address_in == `ADDR_PIN_STATE) begin
        rdata_next = {26'h000_0000, pin_sync_w};
      end else if (avs_address_in == `ADDR_CLOCK_OUT_SELECT_REG) begin
        rdata_next = {30'h0000_0000, clock_out_select_reg};
        if (wr_lane0) clock_out_select_next = wr_byte[1:0];
      end else if (avs_address_in == `ADDR_SW_RESET) begin
        if (wr_lane0) sw_reset_next = wr_byte[0];
      end
    end
    // any core reset puts every pin back on its primary function; writes
    // made while the core is held are acknowledged but dropped, except a software reset write
    if (core_rst_out) begin
      periph_en_next = `PERIPH_EN_RESET;
      sel_c_next = 8'h00;
      sel_f_next = 2'b00;
      gpio_out_next = 6'h00;
      gpio_dir_next = 6'h00;
      clock_out_select_next = 2'b00;
    end
  end

  // the bus handshake only follows power-on so software is never stalled;
  // the control registers are held at their defaults by the logic above
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      periph_en_reg <= `PERIPH_EN_RESET;
      sel_c_reg <= 8'h00;
      sel_f_reg <= 2'b00;
      gpio_out_reg <= 6'h00;
      gpio_dir_reg <= 6'h00;
      clock_out_select_reg <= 2'b00;
      sw_reset_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      periph_en_reg <= periph_en_next;
      sel_c_reg <= sel_c_next;
      sel_f_reg <= sel_f_next;
      gpio_out_reg <= gpio_out_next;
      gpio_dir_reg <= gpio_dir_next;
      clock_out_select_reg <= clock_out_select_next;
      sw_reset_reg <= sw_reset_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  assign avs_readdata_out = rdata_reg;
  assign clock_out_source_sel_out = clock_out_select_reg;
  assign gpio_in_out = pin_sync_w;

  // routing decoded from registers and variant_in, so a register change lands one cycle after
  // the write and never passes through an unrelated function
  assign c0_sel = sel_c_reg[`SEL_C0_LSB];
  assign c2_func = c2_func_t'(sel_c_reg[`SEL_C2_LSB +: 2]);
  assign f8_func = f8_func_t'(sel_f_reg);
  assign c2_per = periph_en_reg[`EN_C2_BIT];
  assign f8_per = periph_en_reg[`EN_F8_BIT];
  assign c2_timer = (variant_in != 2'b00);
  assign f8_timer = (variant_in == 2'b10);

  // test clock pin
  always_comb begin
    debug_test_clock_out = 1'b0;
    debug_test_clock_valid_out = 1'b0;
    test_clock_pin_out = gpio_out_reg[`PIN_D2];
    test_clock_pin_oe_out = 1'b0;
    if (periph_en_reg[`EN_TCK_BIT]) begin
      debug_test_clock_out = pin_sync_w[`PIN_D2];
      debug_test_clock_valid_out = 1'b1;
    end else begin
      test_clock_pin_oe_out = gpio_dir_reg[`PIN_D2];
    end
  end

  // reset pin: input only while it is the reset function
  always_comb begin
    reset_pin_out = gpio_out_reg[`PIN_D4];
    reset_pin_oe_out = 1'b0;
    if (!periph_en_reg[`EN_RST_BIT]) begin
      reset_pin_oe_out = gpio_dir_reg[`PIN_D4];
    end
  end

  // crystal pins
  always_comb begin
    crystal_in_out = 1'b0;
    ext_clock_in_zero_out = 1'b0;
    port_c_bit0_pin_out = gpio_out_reg[`PIN_C0];
    port_c_bit0_pin_oe_out = gpio_dir_reg[`PIN_C0];
    port_c_bit1_pin_out = gpio_out_reg[`PIN_C1];
    port_c_bit1_pin_oe_out = gpio_dir_reg[`PIN_C1];
    if (periph_en_reg[`EN_C0_BIT]) begin
      port_c_bit0_pin_oe_out = 1'b0;
      if (c0_sel) ext_clock_in_zero_out = pin_sync_w[`PIN_C0];
      else crystal_in_out = pin_sync_w[`PIN_C0];
    end
    if (periph_en_reg[`EN_C1_BIT]) begin
      port_c_bit1_pin_out = crystal_out_in;
      port_c_bit1_pin_oe_out = 1'b1;
    end
  end

  // port c bit 2
  always_comb begin
    port_c_bit2_pin_out = gpio_out_reg[`PIN_C2];
    port_c_bit2_pin_oe_out = gpio_dir_reg[`PIN_C2];
    crossbar_input_two_out = 1'b0;
    timer_b_channel_zero_out = 1'b0;
    serial0_receive_out = 1'b1;
    if (c2_per) begin
      case (c2_func)
        C2_TRANSMIT: begin
          port_c_bit2_pin_out = serial0_transmit_in;
          port_c_bit2_pin_oe_out = serial0_single_wire_in ? serial0_transmit_oe_in : 1'b1;
          if (serial0_single_wire_in) serial0_receive_out = pin_sync_w[`PIN_C2];
        end
        C2_CROSS_OR_TIMER: begin
          if (c2_timer) begin
            port_c_bit2_pin_out = timer_b_channel_zero_in;
            port_c_bit2_pin_oe_out = timer_b_channel_zero_oe_in;
            timer_b_channel_zero_out = pin_sync_w[`PIN_C2];
          end else begin
            port_c_bit2_pin_out = crossbar_output_eleven_in;
            port_c_bit2_pin_oe_out = 1'b1;
          end
        end
        C2_CROSS_IN: begin
          port_c_bit2_pin_oe_out = 1'b0;
          crossbar_input_two_out = pin_sync_w[`PIN_C2];
        end
        default: begin
          port_c_bit2_pin_out = clock_sources_in[clock_out_select_reg];
          port_c_bit2_pin_oe_out = 1'b1;
        end
      endcase
    end
    // f8 receive takes priority over single-wire when both selected
    if (f8_per && f8_func == F8_RECEIVE) begin
      serial0_receive_out = pin_sync_w[`PIN_F8];
    end
  end

  // port f bit 8
  always_comb begin
    port_f_bit8_pin_out = gpio_out_reg[`PIN_F8];
    port_f_bit8_pin_oe_out = gpio_dir_reg[`PIN_F8];
    timer_b_channel_one_out = 1'b0;
    if (f8_per) begin
      port_f_bit8_pin_oe_out = 1'b0;
      if (f8_func == F8_CROSS_OR_TIMER) begin
        if (f8_timer) begin
          port_f_bit8_pin_out = timer_b_channel_one_in;
          port_f_bit8_pin_oe_out = timer_b_channel_one_oe_in;
          timer_b_channel_one_out = pin_sync_w[`PIN_F8];
        end else if (variant_in == 2'b00) begin
          port_f_bit8_pin_out = crossbar_output_ten_in;
          port_f_bit8_pin_oe_out = 1'b1;
        end
      end
    end
  end
endmodule

// ==== design/pin_mux_params.svh ====
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// register word offsets
`define ADDR_PERIPH_EN 4'h0
`define ADDR_SEL_C 4'h1
`define ADDR_SEL_D 4'h2
`define ADDR_GPIO_OUT 4'h3
`define ADDR_GPIO_DIR 4'h4
`define ADDR_PIN_STATE 4'h5
`define ADDR_CLOCK_OUT_SELECT_REG 4'h6
`define ADDR_SW_RESET 4'h7

// peripheral enable bit positions
`define EN_TCK_BIT 0
`define EN_RST_BIT 1
`define EN_C0_BIT 2
`define EN_C1_BIT 3
`define EN_C2_BIT 4
`define EN_F8_BIT 5

// pin positions in gpio registers
`define PIN_D2 0
`define PIN_D4 1
`define PIN_C0 2
`define PIN_C1 3
`define PIN_C2 4
`define PIN_F8 5

// selector field positions
`define SEL_C0_LSB 0
`define SEL_C2_LSB 2
`define SEL_F8_LSB 5

`define PERIPH_EN_RESET 8'h03
`define RESET_RELEASE_CYCLES 6'h10
`define SERIAL_CLEAR_NONE 32'h0000_0000

`endif

// ==== design/pin_mux_pkg.sv ====
package pin_mux_pkg;
  typedef enum logic [1:0] {
    C2_TRANSMIT = 2'b00,
    C2_CROSS_OR_TIMER = 2'b01,
    C2_CROSS_IN = 2'b10,
    C2_CLOCK_OUT = 2'b11
  } c2_func_t;
  typedef enum logic [1:0] {
    F8_RECEIVE = 2'b00,
    F8_CROSS_OR_TIMER = 2'b01,
    F8_RESERVED_A = 2'b10,
    F8_RESERVED_B = 2'b11
  } f8_func_t;
  typedef enum logic [1:0] {
    RST_HOLD = 2'b00,
    RST_COUNT = 2'b01,
    RST_RUN = 2'b10
  } rst_state_t;
  typedef logic [5:0] pin_vec_t;
endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
  input wire logic ref_clk_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = d_in;
    sync_next = meta_reg;
  end

  // no reset: the pin is free-running and the stages flush in two cycles
  always_ff @(posedge ref_clk_in) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign q_out = sync_reg;
endmodule

// ==== design/reset_release.sv ====
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module reset_release (
  input wire logic ref_clk_in,
  input wire logic por_in,
  input wire logic hold_in,
  output logic core_rst_out
);
  import pin_mux_pkg::*;
  rst_state_t state_reg;
  rst_state_t state_next;
  logic [5:0] count_reg;
  logic [5:0] count_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (hold_in) begin
      state_next = RST_HOLD;
      count_next = 6'h00;
    end else begin
      case (state_reg)
        RST_HOLD: begin
          state_next = RST_COUNT;
          count_next = 6'h00;
        end
        RST_COUNT: begin
          count_next = count_reg + 6'h01;
          if (count_reg == `RESET_RELEASE_CYCLES - 6'h01) begin
            state_next = RST_RUN;
          end
        end
        default: state_next = RST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (por_in) begin
      state_reg <= RST_HOLD;
      count_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign core_rst_out = (state_reg != RST_RUN);
endmodule

// ==== bench/pin_function_mux_chk.sv ====
`timescale 1ns/1ps
module pin_function_mux_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic watchdog_timeout_reset_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic port_c_bit0_pin_in,
  input wire logic test_clock_pin_in,
  input wire logic [5:0] gpio_in_out,
  input wire logic debug_test_clock_out,
  input wire logic debug_test_clock_valid_out,
  input wire logic [1:0] clock_out_source_sel_out,
  input wire logic core_rst_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_wait_next;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_next: assert property (p_wait_next) else $error("no answer one cycle on");
  property p_rd_unmapped;
    avs_read_in && !avs_waitrequest_out && avs_address_in[3] |-> avs_readdata_out == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_clk_sel;
    avs_write_in && avs_waitrequest_out && avs_address_in == 4'h6 && avs_byteenable_in[0]
      |=> clock_out_source_sel_out == $past(avs_writedata_in[1:0]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock-out select not updated");
  // pins pass through a two-flop synchroniser before anything inside sees them
  property p_sync;
    gpio_in_out[2] == $past(port_c_bit0_pin_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin state lag wrong");
  property p_dbg;
    debug_test_clock_valid_out |-> debug_test_clock_out == $past(test_clock_pin_in, 2);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug clock not the pin");
  property p_por;
    $fell(sys_rst_in) |-> core_rst_out [*8];
  endproperty
  a_por: assert property (p_por) else $error("core reset released early");
  property p_wd_hold;
    $fell(watchdog_timeout_reset_in) |-> core_rst_out [*8];
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog reset too short");
  property p_sw;
    avs_write_in && avs_waitrequest_out && avs_address_in == 4'h7 && avs_byteenable_in[0]
      && avs_writedata_in[0] |-> ##[1:4] core_rst_out;
  endproperty
  a_sw: assert property (p_sw) else $error("software reset ignored");
  c_rd: cover property (avs_read_in && !avs_waitrequest_out);
  c_rel: cover property ($fell(core_rst_out));
  c_dbg: cover property (debug_test_clock_valid_out && $rose(debug_test_clock_out));
endmodule
bind pin_function_mux pin_function_mux_chk u_chk (.*);

// ==== bench/pin_function_mux_bench.sv ====
`timescale 1ns/1ps
module pin_function_mux_bench;
  import pin_mux_pkg::*;
  typedef struct packed {
    logic [7:0] en;
    logic [3:0] selc;
    logic [1:0] self8;
    logic [1:0] vari;
    logic [5:0] exp;
  } row_t;
  // exp holds {c1 oe, c1 level, c2 oe, c2 level, f8 oe, f8 level} for pattern 0
  row_t rows [10] = '{
    '{8'h03, 4'h0, 2'h0, 2'h0, 6'h00}, '{8'h18, 4'h0, 2'h0, 2'h0, 6'h3C},
    '{8'h10, 4'h4, 2'h0, 2'h0, 6'h08}, '{8'h10, 4'h4, 2'h0, 2'h1, 6'h0C},
    '{8'h10, 4'hC, 2'h0, 2'h0, 6'h0C}, '{8'h20, 4'h0, 2'h1, 2'h0, 6'h03},
    '{8'h20, 4'h0, 2'h1, 2'h2, 6'h02}, '{8'h20, 4'h0, 2'h1, 2'h1, 6'h00},
    '{8'h20, 4'h0, 2'h0, 2'h0, 6'h00}, '{8'h10, 4'h8, 2'h0, 2'h0, 6'h00}};
  logic ref_clk_in = 1'h0, sys_rst_in = 1'h1, watchdog_timeout_reset_in = 1'h0;
  logic [1:0] variant_in = 2'h0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF, clock_sources_in = 4'h0;
  logic avs_read_in = 1'h0, avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
  logic test_clock_pin_in = 1'h1, reset_pin_in = 1'h1, port_c_bit0_pin_in = 1'h0;
  logic port_c_bit1_pin_in = 1'h0, port_c_bit2_pin_in = 1'h0, port_f_bit8_pin_in = 1'h0;
  logic crystal_out_in = 1'h0, serial0_transmit_in = 1'h0, serial0_single_wire_in = 1'h0;
  logic serial0_transmit_oe_in = 1'h1, crossbar_output_eleven_in = 1'h0;
  logic crossbar_output_ten_in = 1'h0, timer_b_channel_zero_in = 1'h0;
  logic timer_b_channel_zero_oe_in = 1'h1, timer_b_channel_one_in = 1'h0;
  logic timer_b_channel_one_oe_in = 1'h1, pt;
  logic avs_waitrequest_out, test_clock_pin_out, test_clock_pin_oe_out, reset_pin_out;
  logic reset_pin_oe_out, port_c_bit0_pin_out, port_c_bit0_pin_oe_out, port_c_bit1_pin_out;
  logic port_c_bit1_pin_oe_out, port_c_bit2_pin_out, port_c_bit2_pin_oe_out;
  logic port_f_bit8_pin_out, port_f_bit8_pin_oe_out, debug_test_clock_out;
  logic debug_test_clock_valid_out, crystal_in_out, ext_clock_in_zero_out, serial0_receive_out;
  logic crossbar_input_two_out, timer_b_channel_zero_out, timer_b_channel_one_out, core_rst_out;
  logic [1:0] clock_out_source_sel_out;
  pin_vec_t gpio_in_out;
  int fail_count = 0, check_count = 0, n, n_por;
  wire [5:0] pin_o = {port_f_bit8_pin_out, port_c_bit2_pin_out, port_c_bit1_pin_out,
    port_c_bit0_pin_out, reset_pin_out, test_clock_pin_out};
  wire [5:0] pin_oe = {port_f_bit8_pin_oe_out, port_c_bit2_pin_oe_out, port_c_bit1_pin_oe_out,
    port_c_bit0_pin_oe_out, reset_pin_oe_out, test_clock_pin_oe_out};

  pin_function_mux u_dut (.*);

  always #20 ref_clk_in = ~ref_clk_in;

  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", name, e, g);
      fail_count++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask
  // one access; the request stands until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask
  task automatic rel_count(output int c);
    c = 0;
    while (core_rst_out !== 1'h0 && c < 100) begin
      @(posedge ref_clk_in);
      c++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'h0;
    rel_count(n_por);
    chk("por_release", 32'h1, 32'(n_por >= 16 && n_por <= 20));
    bus(1'h1, 4'h6, 8'h02, rd);
    chk("clk_sel", 32'h2, clock_out_source_sel_out);
    for (int i = 0; i < 10; i++) begin
      variant_in <= rows[i].vari;
      bus(1'h1, 4'h0, rows[i].en, rd);
      bus(1'h1, 4'h1, {4'h0, rows[i].selc}, rd);
      bus(1'h1, 4'h2, {6'h0, rows[i].self8}, rd);
      for (int p = 0; p < 2; p++) begin
        pt = 1'(p);
        {crystal_out_in, serial0_transmit_in, timer_b_channel_zero_in} <= {3{~pt}};
        {crossbar_output_ten_in, crossbar_output_eleven_in} <= {~pt, pt};
        timer_b_channel_one_in <= pt;
        clock_sources_in <= {4{pt}} ^ 4'h4;
        tick(2);
        chk("c1_oe", rows[i].exp[5], port_c_bit1_pin_oe_out);
        if (rows[i].exp[5]) chk("c1", rows[i].exp[4] ^ pt, port_c_bit1_pin_out);
        chk("c2_oe", rows[i].exp[3], port_c_bit2_pin_oe_out);
        if (rows[i].exp[3]) chk("c2", rows[i].exp[2] ^ pt, port_c_bit2_pin_out);
        chk("f8_oe", rows[i].exp[1], port_f_bit8_pin_oe_out);
        if (rows[i].exp[1]) chk("f8", rows[i].exp[0] ^ pt, port_f_bit8_pin_out);
      end
    end
    bus(1'h1, 4'h0, 8'h03, rd);
    for (int k = 0; k < 2; k++) begin
      test_clock_pin_in <= 1'(k);
      tick(4);
      chk("tck", {2'h2, 1'(k), 1'h0}, {2'h2, debug_test_clock_out, test_clock_pin_oe_out});
      chk("tck_valid", 32'h1, debug_test_clock_valid_out);
    end
    reset_pin_in <= 1'h0;
    tick(6);
    chk("pin_reset", 32'h1, core_rst_out);
    chk("rst_pin_oe", 32'h0, reset_pin_oe_out);
    reset_pin_in <= 1'h1;
    rel_count(n);
    chk("pin_release", 32'h1, 32'(n >= n_por && n <= n_por + 4));
    bus(1'h1, 4'h0, 8'h00, rd);
    bus(1'h1, 4'h4, 8'h3F, rd);
    bus(1'h1, 4'h3, 8'h2A, rd);
    chk("gpio_out", 32'h2A, pin_o);
    chk("gpio_oe", 32'h3F, pin_oe);
    bus(1'h1, 4'h4, 8'h15, rd);
    chk("gpio_dir", 32'h15, pin_oe);
    bus(1'h1, 4'h4, 8'h00, rd);
    // reset pin held low here on purpose: as a plain input it must not reset
    {port_f_bit8_pin_in, port_c_bit2_pin_in, port_c_bit1_pin_in} <= 3'h4;
    {port_c_bit0_pin_in, reset_pin_in, test_clock_pin_in} <= 3'h5;
    tick(8);
    chk("gpio_in", 32'h25, gpio_in_out);
    chk("no_pin_reset", 32'h0, core_rst_out);
    bus(1'h0, 4'h5, 8'h00, rd);
    chk("pin_state", 32'h25, rd);
    reset_pin_in <= 1'h1;
    watchdog_timeout_reset_in <= 1'h1;
    tick(4);
    chk("wd_reset", 32'h1, core_rst_out);
    watchdog_timeout_reset_in <= 1'h0;
    rel_count(n);
    chk("wd_release", n_por, n);
    bus(1'h0, 4'h0, 8'h00, rd);
    chk("wd_en", 32'h03, rd);
    bus(1'h1, 4'h7, 8'h01, rd);
    tick(2);
    chk("sw_reset", 32'h1, core_rst_out);
    rel_count(n);
    bus(1'h1, 4'h0, 8'h34, rd);
    bus(1'h1, 4'h2, 8'h00, rd);
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, 4'h1, 8'h08 | 8'(s), rd);
      for (int k = 0; k < 2; k++) begin
        {port_c_bit0_pin_in, port_c_bit2_pin_in, port_f_bit8_pin_in} <= {3{1'(k)}};
        tick(4);
        chk("inputs", {1'(k & ~s), 1'(k & s), 1'(k), 1'(k)}, {crystal_in_out,
          ext_clock_in_zero_out, crossbar_input_two_out, serial0_receive_out});
      end
    end
    // third variant: both timer channels read their synced pins
    variant_in <= 2'h2;
    bus(1'h1, 4'h1, 8'h04, rd);
    bus(1'h1, 4'h2, 8'h01, rd);
    chk("timers", 32'h3, {timer_b_channel_zero_out, timer_b_channel_one_out});
    // single-wire transmit: pin released, receive taken from this pin
    {serial0_single_wire_in, serial0_transmit_oe_in, port_c_bit2_pin_in} <= 3'h4;
    bus(1'h1, 4'h1, 8'h00, rd);
    bus(1'h1, 4'h2, 8'h02, rd);
    chk("single_wire", 32'h0, {port_c_bit2_pin_oe_out, serial0_receive_out});
    sys_rst_in <= 1'h1;
    tick(16);
    sys_rst_in <= 1'h0;
    bus(1'h0, 4'h0, 8'h00, rd);
    chk("en_reset", 32'h03, rd);
    bus(1'h1, 4'h8, 8'hFF, rd);
    foreach (rows[a]) begin
      if (a != 0 && a != 5) begin
        bus(1'h0, 4'(a), 8'h00, rd);
        chk("reg_reset", 32'h0, rd);
      end
    end
    tally_and_finish();
  end
endmodule
